/* File: rtl/apds_sequencer.sv */
// axis pulse drive sequencer: APB registers, drive control, stop handling
// Behaviour
// - fixed drives count out; continuous runs until stopped
// - relative: sign of count gives direction
// - auto decelerate when remaining below acceleration pulses
// - code 50h starts relative drive
// - absolute: direction and count from target minus position
// - code 54h starts absolute drive
// - counter relative drives opposite to count sign
// - code 51h starts counter relative drive
// - target count may change during relative drives
// - raised count during deceleration accelerates again
// - count below pulses output stops at once
// - mode bit 0 selects manual point, code 07h
// - positive offset starts auto deceleration earlier
// - deceleration offset resets to zero
// - decelerating stop and instant stop commands
// - three external stops, enable and level each
// - codes 52h and 53h start continuous drives
// - symmetric: deceleration uses the acceleration rate
// - cruise below start speed: constant, instant stop
`default_nettype none
module apds_sequencer
  import apds_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  output logic [DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_stop_in_a,
  input wire logic external_stop_in_b,
  input wire logic external_stop_in_c,
  output logic drive_pulse,
  output logic drive_dir,
  output logic drive_busy
);
  typedef struct packed {
    logic [DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [DW-1:0] tpc;
    logic [DW-1:0] sv;
    logic [DW-1:0] dv;
    logic [DW-1:0] rate;
    logic [MODE_W-1:0] mode;
    logic [DW-1:0] mpt_stage;
    logic [DW-1:0] mpt;
    logic [DW-1:0] ofs;
    logic [DW-1:0] lpos;
    logic [DW-1:0] total;
    logic [DW-1:0] out_cnt;
    logic [DW-1:0] acc_cnt;
    logic [SPD_W-1:0] speed;
    logic [TICK_W-1:0] tick;
    apds_phase_t phase;
    logic busy;
    logic cont;
    logic ovr_ok;
    logic const_mode;
    logic stop_dec;
    logic dir;
    logic pulse;
  } apds_seq_state_t;

  apds_seq_state_t r;
  apds_seq_state_t n;
  logic [2:0] stop_sync;
  apds_pulse_if pg ();

  apds_stop_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({external_stop_in_c, external_stop_in_b, external_stop_in_a}),
    .sync_out(stop_sync)
  );

  apds_pulse_gen u_gen (
    .pclk(pclk),
    .presetn(presetn),
    .pg(pg)
  );

  function automatic logic [DW-1:0] magnitude(input logic [DW-1:0] v);
    magnitude = v[DW-1] ? DW'(-v) : v;
  endfunction

  function automatic logic is_mapped(input logic [AW-1:0] a);
    is_mapped = (a <= ADDR_OUTC) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_drive_cmd(input logic [7:0] c);
    is_drive_cmd = (c == CMD_REL) || (c == CMD_CNT_REL) ||
      (c == CMD_ABS) || (c == CMD_CONT_P) || (c == CMD_CONT_M);
  endfunction

  logic acc_wr;
  logic cmd_wr;
  logic [7:0] cmd;
  logic [DW-1:0] rem;
  logic [DW-1:0] rem_next;
  logic [DW-1:0] abs_diff;
  logic [DW-1:0] new_total;
  logic [2:0] ext_act;
  logic low_speed;
  logic dec_need;
  logic tick_hit;
  logic [SPD_W:0] spd_up;
  logic [SPD_W:0] spd_dn;

  always_comb
  begin
    acc_wr = psel & penable & r.pready & pwrite;
    cmd_wr = acc_wr && (paddr == ADDR_CMD);
    cmd = pwdata[7:0];
    rem = r.total - r.out_cnt;
    abs_diff = r.tpc - r.lpos;
    new_total = magnitude(pwdata);
    // enabled pin whose synced level equals its active level
    ext_act = r.mode[MODE_EN_LSB +: 3] &
      ~(stop_sync ^ r.mode[MODE_LVL_LSB +: 3]);
    low_speed = r.const_mode || (r.speed <= r.sv[SPD_W-1:0]);
    tick_hit = (r.tick == TICK_W'(RAMP_TICK_CYC - 1));
    // same rate both ways: no separate deceleration setting
    spd_up = {1'b0, r.speed} + {1'b0, r.rate[SPD_W-1:0]};
    spd_dn = {1'b0, r.speed} - {1'b0, r.rate[SPD_W-1:0]};
    if (r.mode[MODE_MAN_BIT])
      dec_need = rem <= r.mpt;
    else
      dec_need = $signed({1'b0, rem}) <=
        $signed({1'b0, r.acc_cnt}) + $signed({r.ofs[DW-1], r.ofs});
    dec_need = r.stop_dec || (!r.cont && dec_need);
  end

  // a pulse still inside the generator flop counts as already output
  assign pg.run = r.busy && (r.cont || rem > {{(DW-1){1'b0}}, pg.pulse});
  assign pg.speed = r.speed;

  always_comb
  begin
    n = r;
    rem_next = rem;
    n.pready = 1'b1;
    // a carry caught in the stop cycle is neither counted nor sent
    n.pulse = pg.pulse && r.busy;
    if (psel && !penable)
    begin
      n.pslverr = !is_mapped(paddr);
      case (paddr)
        ADDR_TPC: n.prdata = r.tpc;
        ADDR_SV: n.prdata = r.sv;
        ADDR_DV: n.prdata = r.dv;
        ADDR_RATE: n.prdata = r.rate;
        ADDR_MODE: n.prdata = {{(DW-MODE_W){1'b0}}, r.mode};
        ADDR_MPT: n.prdata = r.mpt;
        ADDR_OFS: n.prdata = r.ofs;
        ADDR_STAT: n.prdata = {{(DW-STAT_W){1'b0}}, r.phase,
          r.stop_dec, r.const_mode, r.cont, r.dir, r.busy};
        ADDR_LPOS: n.prdata = r.lpos;
        ADDR_OUTC: n.prdata = r.out_cnt;
        default: n.prdata = RST_WORD;
      endcase
    end
    if (acc_wr)
    begin
      case (paddr)
        ADDR_TPC: n.tpc = pwdata;
        ADDR_SV: n.sv = pwdata;
        ADDR_DV: n.dv = pwdata;
        ADDR_RATE: n.rate = pwdata;
        ADDR_MODE: n.mode = pwdata[MODE_W-1:0];
        ADDR_MPT: n.mpt_stage = pwdata;
        ADDR_OFS: n.ofs = pwdata;
        ADDR_LPOS: n.lpos = r.busy ? r.lpos : pwdata;
        default: n.tpc = n.tpc;
      endcase
    end
    if (cmd_wr && cmd == CMD_MAN_DEC)
      n.mpt = r.mpt_stage;
    if (!r.busy)
    begin
      if (cmd_wr && is_drive_cmd(cmd))
      begin
        // parameters are taken now; busy and the rate generator start next cycle
        n.busy = 1'b1;
        n.out_cnt = '0;
        n.acc_cnt = '0;
        n.tick = '0;
        n.stop_dec = 1'b0;
        n.const_mode = r.dv < r.sv;
        n.speed = n.const_mode ? r.dv[SPD_W-1:0] : r.sv[SPD_W-1:0];
        n.phase = n.const_mode ? PH_CRUISE : PH_ACCEL;
        n.cont = 1'b0;
        n.ovr_ok = 1'b0;
        case (cmd)
          CMD_REL:
          begin
            n.dir = !r.tpc[DW-1];
            n.total = magnitude(r.tpc);
            n.ovr_ok = 1'b1;
          end
          CMD_CNT_REL:
          begin
            n.dir = r.tpc[DW-1];
            n.total = magnitude(r.tpc);
            n.ovr_ok = 1'b1;
          end
          CMD_ABS:
          begin
            n.dir = !abs_diff[DW-1];
            n.total = magnitude(abs_diff);
          end
          CMD_CONT_P:
          begin
            n.dir = 1'b1;
            n.cont = 1'b1;
          end
          default:
          begin
            n.dir = 1'b0;
            n.cont = 1'b1;
          end
        endcase
      end
    end
    else
    begin
      n.tick = tick_hit ? '0 : r.tick + TICK_W'(1);
      if (pg.pulse)
      begin
        n.out_cnt = r.out_cnt + 32'h0000_0001;
        n.lpos = r.dir ? r.lpos + 32'h0000_0001 : r.lpos - 32'h0000_0001;
        rem_next = rem - 32'h0000_0001;
        if (r.phase == PH_ACCEL)
          n.acc_cnt = r.acc_cnt + 32'h0000_0001;
      end
      if (!r.const_mode)
      begin
        // recomputed every cycle, so a raised count leaves decel
        if (dec_need)
        begin
          n.phase = PH_DECEL;
          if (tick_hit)
            n.speed = (spd_dn[SPD_W] || spd_dn[SPD_W-1:0] <
              r.sv[SPD_W-1:0]) ? r.sv[SPD_W-1:0] : spd_dn[SPD_W-1:0];
          if (r.stop_dec && r.speed <= r.sv[SPD_W-1:0])
            n.busy = 1'b0;
        end
        else if (r.speed < r.dv[SPD_W-1:0])
        begin
          n.phase = PH_ACCEL;
          if (tick_hit)
            n.speed = (spd_up[SPD_W] || spd_up[SPD_W-1:0] >
              r.dv[SPD_W-1:0]) ? r.dv[SPD_W-1:0] : spd_up[SPD_W-1:0];
        end
        else
        begin
          n.phase = PH_CRUISE;
          n.speed = r.dv[SPD_W-1:0];
        end
      end
      if (!r.cont && rem_next == '0)
        n.busy = 1'b0;
      if (acc_wr && paddr == ADDR_TPC && r.ovr_ok)
      begin
        // only same-direction values are meaningful here
        if (new_total <= n.out_cnt)
          n.busy = 1'b0;
        else
          n.total = new_total;
      end
      if (|ext_act)
      begin
        if (low_speed)
          n.busy = 1'b0;
        else
          n.stop_dec = 1'b1;
      end
      if (cmd_wr && cmd == CMD_DEC_STOP)
      begin
        if (low_speed)
          n.busy = 1'b0;
        else
          n.stop_dec = 1'b1;
      end
      if (cmd_wr && cmd == CMD_INST_STOP)
        n.busy = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.mode <= RST_MODE;
      r.ofs <= RST_OFFSET;
      r.phase <= PH_CRUISE;
    end
    else
      r <= n;
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign drive_pulse = r.pulse;
  assign drive_dir = r.dir;
  assign drive_busy = r.busy;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_start(logic [7:0] code);
    !r.busy && cmd_wr && cmd == code;
  endsequence

  sequence s_running_fixed;
    r.busy && !r.cont;
  endsequence

  a_start_next_cycle: assert property (
    !r.busy && cmd_wr && is_drive_cmd(cmd) |=> r.busy ##1 r.busy || rem == 0)
    else $error("drive did not start after command");

  a_rel_direction: assert property (
    s_start(CMD_REL) |=> r.dir == !$past(r.tpc[DW-1]) &&
      r.total == magnitude($past(r.tpc)))
    else $error("relative drive direction or count wrong");

  a_cnt_direction: assert property (
    s_start(CMD_CNT_REL) |=> r.dir == $past(r.tpc[DW-1]))
    else $error("counter relative direction wrong");

  a_abs_target: assert property (
    s_start(CMD_ABS) |=> r.total == magnitude($past(abs_diff)) &&
      r.dir == !$past(abs_diff[DW-1]))
    else $error("absolute drive target wrong");

  a_cont_start: assert property (
    s_start(CMD_CONT_M) |=> r.cont && !r.dir ##1 r.busy || $past(|ext_act))
    else $error("minus continuous drive did not start");

  a_fixed_end: assert property (
    s_running_fixed ##0 rem_next == 0 |=> !r.busy && !drive_busy)
    else $error("fixed drive did not end at zero remaining");

  a_auto_decel: assert property (
    s_running_fixed ##0 !r.const_mode && !r.mode[MODE_MAN_BIT] &&
      $signed({1'b0, rem}) < $signed({1'b0, r.acc_cnt}) +
      $signed({r.ofs[DW-1], r.ofs}) && rem_next != 0 &&
      !(acc_wr && paddr == ADDR_TPC) |=> r.phase == PH_DECEL || !r.busy)
    else $error("automatic deceleration missed");

  a_override_stop: assert property (
    r.busy && r.ovr_ok && acc_wr && paddr == ADDR_TPC &&
      new_total <= n.out_cnt |=> !r.busy)
    else $error("smaller count did not stop output");

  a_instant_stop: assert property (
    r.busy && cmd_wr && cmd == CMD_INST_STOP |=> !r.busy [*2])
    else $error("instant stop did not stop");

  a_const_speed: assert property (
    r.busy && r.const_mode |-> r.speed == r.dv[SPD_W-1:0])
    else $error("constant speed drive changed speed");

  a_ext_stop: assert property (
    r.busy && (|ext_act) && low_speed |=> !r.busy)
    else $error("external stop at low speed not instant");
endmodule
`default_nettype wire

/* File: include/apds_pkg.sv */
// constants and types shared by the axis pulse drive sequencer
`default_nettype none
package apds_pkg;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int SPD_W = 24;
  localparam int MODE_W = 7;
  localparam int STAT_W = 7;

  // register byte offsets
  localparam logic [AW-1:0] ADDR_CMD = 8'h00;
  localparam logic [AW-1:0] ADDR_TPC = 8'h04;
  localparam logic [AW-1:0] ADDR_SV = 8'h08;
  localparam logic [AW-1:0] ADDR_DV = 8'h0C;
  localparam logic [AW-1:0] ADDR_RATE = 8'h10;
  localparam logic [AW-1:0] ADDR_MODE = 8'h14;
  localparam logic [AW-1:0] ADDR_MPT = 8'h18;
  localparam logic [AW-1:0] ADDR_OFS = 8'h1C;
  localparam logic [AW-1:0] ADDR_STAT = 8'h20;
  localparam logic [AW-1:0] ADDR_LPOS = 8'h24;
  localparam logic [AW-1:0] ADDR_OUTC = 8'h28;

  // command codes
  localparam logic [7:0] CMD_REL = 8'h50;
  localparam logic [7:0] CMD_CNT_REL = 8'h51;
  localparam logic [7:0] CMD_CONT_P = 8'h52;
  localparam logic [7:0] CMD_CONT_M = 8'h53;
  localparam logic [7:0] CMD_ABS = 8'h54;
  localparam logic [7:0] CMD_MAN_DEC = 8'h07;
  localparam logic [7:0] CMD_DEC_STOP = 8'h26;
  localparam logic [7:0] CMD_INST_STOP = 8'h27;

  // drive_mode_register fields
  localparam int MODE_MAN_BIT = 0;
  localparam int MODE_EN_LSB = 1;
  localparam int MODE_LVL_LSB = 4;

  // reset values
  localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [DW-1:0] RST_OFFSET = 32'h0000_0000;
  localparam logic [MODE_W-1:0] RST_MODE = 7'h00;

  // speed ramp step period
  localparam int CLK_PERIOD_NS = 20;
  localparam int RAMP_TICK_NS = 1000;
  localparam int RAMP_TICK_CYC =
    (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 6;

  typedef enum logic [1:0] {PH_ACCEL, PH_CRUISE, PH_DECEL} apds_phase_t;
endpackage
`default_nettype wire

/* File: include/apds_pulse_if.sv */
// link between sequencer control and the pulse rate generator
`default_nettype none
interface apds_pulse_if
  import apds_pkg::*;
  ();
  logic run;
  logic [SPD_W-1:0] speed;
  logic pulse;
  modport ctrl (output run, output speed, input pulse);
  modport gen (input run, input speed, output pulse);
endinterface
`default_nettype wire

/* File: rtl/apds_stop_sync.sv */
// two-flop synchroniser for the external stop pins
`default_nettype none
module apds_stop_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } apds_sync_state_t;

  apds_sync_state_t r;
  apds_sync_state_t n;

  always_comb
  begin
    n = r;
    n.s1 = async_in;
    n.s2 = r.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign sync_out = r.s2;
endmodule
`default_nettype wire

/* File: rtl/apds_pulse_gen.sv */
// phase accumulator producing one-cycle drive pulses at a given rate
`default_nettype none
module apds_pulse_gen
  import apds_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  apds_pulse_if.gen pg
);
  typedef struct packed {
    logic [SPD_W-1:0] acc;
    logic pulse;
  } apds_pg_state_t;

  apds_pg_state_t r;
  apds_pg_state_t n;

  always_comb
  begin
    n = r;
    n.pulse = 1'b0;
    // carry out of the accumulator is the pulse; rate = speed/2^24 per clock
    if (pg.run)
      {n.pulse, n.acc} = {1'b0, r.acc} + {1'b0, pg.speed};
    else
      n.acc = '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign pg.pulse = r.pulse;
endmodule
`default_nettype wire

/* File: verification/apds_motor_model.sv */
// motor driver stand-in: counts step pulses and tracks the position
`default_nettype none
module apds_motor_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drive_pulse,
  input wire logic drive_dir,
  output logic [31:0] step_total,
  output logic [31:0] step_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driver latches direction with each step, as a real stage does
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_total <= 32'h0000_0000;
      step_pos <= 32'h0000_0000;
    end
    else if (drive_pulse === 1'b1)
    begin
      step_total <= step_total + 32'h0000_0001;
      step_pos <= drive_dir ? step_pos + 32'h0000_0001
                            : step_pos - 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the axis pulse drive sequencer
`default_nettype none
module tb
  import apds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = 8'h00;
  logic [DW-1:0] pwdata = 32'h0000_0000;
  logic [DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] ext = 3'h0;
  logic drive_pulse;
  logic drive_dir;
  logic drive_busy;
  logic [31:0] cnt;
  logic [31:0] pos;
  logic [31:0] c0;
  logic [31:0] p0;
  logic [31:0] k;
  logic err;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  apds_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_stop_in_a(ext[0]), .external_stop_in_b(ext[1]),
    .external_stop_in_c(ext[2]), .drive_pulse(drive_pulse),
    .drive_dir(drive_dir), .drive_busy(drive_busy));
  apds_motor_model u_motor (.pclk(pclk), .presetn(presetn),
    .drive_pulse(drive_pulse), .drive_dir(drive_dir),
    .step_total(cnt), .step_pos(pos));

  always #10 pclk = ~pclk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // whole run needs well under this; a hang ends here
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [AW-1:0] a,
    input logic [DW-1:0] d, output logic [DW-1:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic chk_rd(input string n, input logic [AW-1:0] a,
    input logic [31:0] e);
    logic [DW-1:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(n, e, q);
  endtask

  task automatic wait_stop(input int bound);
    int n;
    n = 0;
    while (drive_busy !== 1'b0 && n < bound)
    begin
      @(posedge pclk);
      n++;
    end
    chk("stopped", 32'h0000_0000, {31'h0000_0000, drive_busy});
  endtask

  task automatic start(input logic [7:0] cmd);
    c0 = cnt;
    p0 = pos;
    wr(ADDR_CMD, {24'h00_0000, cmd});
    @(posedge pclk);
    #1;
    chk("busy", 32'h0000_0001, {31'h0000_0000, drive_busy});
  endtask

  // fixed drives: exact pulse total and signed position change
  task automatic finish(input logic [31:0] n, input logic [31:0] dp);
    wait_stop(5000);
    repeat (4) @(posedge pclk);
    chk("pulses", n, cnt - c0);
    chk("position", dp, pos - p0);
  endtask

  task automatic cont(input logic [7:0] cmd, input logic d,
    input logic [7:0] stop, input int bound);
    start(cmd);
    repeat (200) @(posedge pclk);
    #1;
    chk("direction", {31'h0000_0000, d}, {31'h0000_0000, drive_dir});
    wr(ADDR_CMD, {24'h00_0000, stop});
    wait_stop(bound);
  endtask

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_rd("offset", ADDR_OFS, RST_OFFSET);
    chk_rd("mode", ADDR_MODE, 32'h0000_0000);
    chk_rd("unmapped", 8'h30, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
    // cruise below start speed gives a constant-rate drive
    wr(ADDR_SV, 32'h0040_0000);
    wr(ADDR_DV, 32'h0020_0000);
    wr(ADDR_RATE, 32'h0001_0000);
    wr(ADDR_TPC, 32'h0000_000A);
    start(CMD_REL);
    finish(32'h0000_000A, 32'h0000_000A);
    wr(ADDR_TPC, 32'hFFFF_FFFB);
    start(CMD_REL);
    finish(32'h0000_0005, 32'hFFFF_FFFB);
    wr(ADDR_TPC, 32'hFFFF_FFFD);
    start(CMD_CNT_REL);
    finish(32'h0000_0003, 32'h0000_0003);
    wr(ADDR_TPC, 32'hFFFF_FFFC);
    start(CMD_ABS);
    finish(32'h0000_000C, 32'hFFFF_FFF4);
    chk_rd("lpos", ADDR_LPOS, pos);
    wr(ADDR_TPC, 32'h0000_00C8);
    start(CMD_REL);
    repeat (80) @(posedge pclk);
    k = cnt - c0;
    wr(ADDR_TPC, 32'h0000_0002);
    wait_stop(20);
    chk("early end", 32'h0000_0001, {31'h0, (cnt - c0) <= k + 2});
    cont(CMD_CONT_P, 1'b1, CMD_DEC_STOP, 12);
    // ramped profile: acceleration rate reused for deceleration
    wr(ADDR_SV, 32'h0010_0000);
    wr(ADDR_DV, 32'h0040_0000);
    wr(ADDR_RATE, 32'h0008_0000);
    wr(ADDR_TPC, 32'h0000_003C);
    start(CMD_REL);
    finish(32'h0000_003C, 32'h0000_003C);
    wr(ADDR_TPC, 32'h0000_0028);
    start(CMD_REL);
    // well inside the deceleration, far from the natural end
    repeat (300) @(posedge pclk);
    wr(ADDR_TPC, 32'h0000_0050);
    finish(32'h0000_0050, 32'h0000_0050);
    wr(ADDR_OFS, 32'h0000_0005);
    wr(ADDR_TPC, 32'h0000_003C);
    start(CMD_REL);
    finish(32'h0000_003C, 32'h0000_003C);
    wr(ADDR_OFS, 32'h0000_0000);
    wr(ADDR_MODE, 32'h0000_0001);
    wr(ADDR_MPT, 32'h0000_000A);
    wr(ADDR_CMD, {24'h00_0000, CMD_MAN_DEC});
    chk_rd("manual point", ADDR_MPT, 32'h0000_000A);
    wr(ADDR_TPC, 32'h0000_0028);
    start(CMD_REL);
    finish(32'h0000_0028, 32'h0000_0028);
    cont(CMD_CONT_M, 1'b0, CMD_INST_STOP, 8);
    start(CMD_CONT_P);
    repeat (400) @(posedge pclk);
    wr(ADDR_CMD, {24'h00_0000, CMD_DEC_STOP});
    #1;
    chk("ramping down", 32'h1, {31'h0, drive_busy});
    wait_stop(800);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_MODE, (32'h0000_0002 << i) | (32'h0000_0010 << i));
      start(CMD_CONT_P);
      repeat (100) @(posedge pclk);
      #1;
      chk("not yet", 32'h1, {31'h0, drive_busy});
      @(posedge pclk);
      ext[i] <= 1'b1;
      wait_stop(800);
      ext[i] <= 1'b0;
    end
    print_verdict();
  end
endmodule
`default_nettype wire
